// file: verilog/tua_pkg.sv
// Purpose: Shared constants and types of the time-of-use accumulator
// Assumes: Dates are packed as {month[3:0], day[4:0]}, months 1..12
// Notes: Memory address widths are sized to hold the depths below
package tua_pkg;
  localparam int NUM_CAL = 20;
  localparam int NUM_SCHED = 16;
  localparam int NUM_RATE = 8;
  localparam int NUM_SEASON = 4;
  localparam int NUM_MONTH = 12;
  localparam int DAYS_PER_CAL = 366;
  localparam int SLOTS_PER_DAY = 96;
  localparam int SLOTS_PER_HOUR = 4;
  localparam int MIN_PER_SLOT = 15;
  localparam int CAL_DEPTH = NUM_CAL * DAYS_PER_CAL;
  localparam int SCH_DEPTH = NUM_SCHED * SLOTS_PER_DAY;
  localparam int CAL_AW = 13;
  localparam int SCH_AW = 11;
  localparam int SCHED_W = 4;
  localparam int RATE_W = 3;
  localparam int CAL_IDX_W = 5;
  localparam int DOY_W = 9;
  localparam int SLOT_W = 7;
  localparam int YEAR_W = 8;
  localparam int DATE_W = 9;
  localparam int ACC_W = 32;
  localparam int INC_W = 16;
  localparam logic [3:0] FIRST_MONTH = 4'h1;
  localparam logic [3:0] LAST_MONTH = 4'hC;
  localparam logic [4:0] LAST_DAY = 5'h1F;
  localparam logic [4:0] LAST_HOUR = 5'h17;
  localparam logic [5:0] LAST_MIN = 6'h3B;
  localparam logic [5:0] LAST_SEC = 6'h3B;

  typedef logic [DATE_W-1:0] tua_date_t;
  typedef logic [ACC_W-1:0] tua_acc_t;

  typedef enum logic [1:0] {
    SET_SEASON_ACTIVE,
    SET_SEASON_FROZEN,
    SET_MONTH_ACTIVE,
    SET_MONTH_FROZEN
  } tua_set_t;
endpackage : tua_pkg

// file: verilog/tua_mem_if.sv
// Purpose: Carrier between the accumulator core and its lookup memories
// Assumes: One write port, two independent read ports
// Notes: Read data appear one clock after the read address
`timescale 1ns/1ps
interface tua_mem_if #(
  parameter int W = 4,
  parameter int AW = 13
) ();
  logic we;
  logic [AW-1:0] waddr;
  logic [W-1:0] wdata;
  logic [AW-1:0] raddr_a;
  logic [AW-1:0] raddr_b;
  logic [W-1:0] rdata_a;
  logic [W-1:0] rdata_b;

  modport owner (output we, waddr, wdata, raddr_a, raddr_b, input rdata_a, rdata_b);
  modport mem (input we, waddr, wdata, raddr_a, raddr_b, output rdata_a, rdata_b);
endinterface : tua_mem_if

// file: verilog/tua_mem.sv
// Purpose: Small two-read, one-write memory with registered read data
// Assumes: Addresses beyond DEPTH read as zero and are not written
// Notes: Array content has no reset; software loads it before use
`timescale 1ns/1ps
module tua_mem #(
  parameter int W = 4,
  parameter int AW = 13,
  parameter int DEPTH = 7320
) (
  input wire logic clk,
  input wire logic reset,
  tua_mem_if.mem m
);
  typedef struct packed {
    logic [W-1:0] rdata_a;
    logic [W-1:0] rdata_b;
  } tua_mem_state_t;

  logic [W-1:0] store [DEPTH];
  tua_mem_state_t s;
  tua_mem_state_t next_s;

  always_ff @(posedge clk)
  begin
    if (m.we && (int'(m.waddr) < DEPTH))
    begin
      store[m.waddr] <= m.wdata;
    end
  end

  always_comb
  begin
    next_s = s;
    next_s.rdata_a = (int'(m.raddr_a) < DEPTH) ? store[m.raddr_a] : '0;
    next_s.rdata_b = (int'(m.raddr_b) < DEPTH) ? store[m.raddr_b] : '0;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign m.rdata_a = s.rdata_a;
  assign m.rdata_b = s.rdata_b;
endmodule : tua_mem

// file: verilog/tua_accum.sv
// Purpose: Time-of-use energy accumulator with calendars, seasons and months
// Assumes: Time base and energy increments come from logic on clk
// Notes: Period dates are latched at each period start, not tracked live
//
// What this block does
// - Holds up to twenty yearly calendars at once.
// - Each calendar day picks one of up to 16 day schedules.
// - A schedule covers the day in quarter-hour slots, 00:00:00 to 23:59:59.
// - Each slot selects one of eight rate registers that receives energy.
// - Keeps seasonal accumulations, at most four seasons a year.
// - Keeps a separate set of monthly billing accumulations.
// - A start or billing date also ends the prior period; may cross years.
// - A season closes at midnight ending the day before next start.
// - A month closes at midnight on its billing day.
// - At year end without next-year calendar, accumulation halts.
// - With next-year calendar, open periods continue across the year.
// - Without next-year calendar, last period ends December 31 23:59:59.
// - At period end, copy active to frozen, clear active, continue.
// - Frozen and active sets are readable at any time.
// - Loading calendars never stops accumulation; readback one at a time.
// - A replaced calendar runs the current period to its latched end.
// - Reset clears active only, restarts now, takes new end dates.
// - Frozen sets are never changed by a reset command.
// - At the year boundary switch to next year's calendar if present.
`timescale 1ns/1ps
module tua_accum (
  input wire logic clk,
  input wire logic reset,
  input wire logic rtc_tick,
  input wire logic [tua_pkg::YEAR_W-1:0] rtc_year,
  input wire logic [3:0] rtc_month,
  input wire logic [4:0] rtc_day,
  input wire logic [tua_pkg::DOY_W-1:0] rtc_doy,
  input wire logic [4:0] rtc_hour,
  input wire logic [5:0] rtc_minute,
  input wire logic [5:0] rtc_second,
  input wire logic energy_valid,
  input wire logic [tua_pkg::INC_W-1:0] energy_inc,
  input wire logic cal_wr_en,
  input wire logic [tua_pkg::CAL_IDX_W-1:0] cal_wr_slot,
  input wire logic [tua_pkg::DOY_W-1:0] cal_wr_day,
  input wire logic [tua_pkg::SCHED_W-1:0] cal_wr_sched,
  input wire logic cal_tag_wr,
  input wire logic [tua_pkg::CAL_IDX_W-1:0] cal_tag_slot,
  input wire logic [tua_pkg::YEAR_W-1:0] cal_tag_year,
  input wire logic cal_tag_valid,
  input wire logic sch_wr_en,
  input wire logic [tua_pkg::SCHED_W-1:0] sch_wr_id,
  input wire logic [tua_pkg::SLOT_W-1:0] sch_wr_slot,
  input wire logic [tua_pkg::RATE_W-1:0] sch_wr_rate,
  input wire logic [tua_pkg::NUM_SEASON-1:0][tua_pkg::DATE_W-1:0] cfg_season_start,
  input wire logic [tua_pkg::NUM_MONTH-1:0][4:0] cfg_bill_day,
  input wire logic acc_reset,
  input wire logic [tua_pkg::CAL_IDX_W-1:0] cal_rd_slot,
  input wire logic [tua_pkg::DOY_W-1:0] cal_rd_day,
  output logic [tua_pkg::SCHED_W-1:0] cal_rd_sched,
  input wire logic [tua_pkg::SCHED_W-1:0] sch_rd_id,
  input wire logic [tua_pkg::SLOT_W-1:0] sch_rd_slot,
  output logic [tua_pkg::RATE_W-1:0] sch_rd_rate,
  input wire tua_pkg::tua_set_t rd_set,
  input wire logic [tua_pkg::RATE_W-1:0] rd_rate,
  output tua_pkg::tua_acc_t rd_data,
  output logic running,
  output logic [tua_pkg::CAL_IDX_W-1:0] active_cal,
  output logic season_frozen,
  output logic month_frozen
);
  import tua_pkg::*;

  typedef struct packed {
    logic halted;
    logic [CAL_IDX_W-1:0] cal_slot;
    tua_date_t season_end;
    tua_date_t month_end;
    logic [NUM_CAL-1:0] tag_valid;
    logic [NUM_CAL-1:0][YEAR_W-1:0] tag_year;
    logic [NUM_RATE-1:0][ACC_W-1:0] season_act;
    logic [NUM_RATE-1:0][ACC_W-1:0] season_frz;
    logic [NUM_RATE-1:0][ACC_W-1:0] month_act;
    logic [NUM_RATE-1:0][ACC_W-1:0] month_frz;
    tua_acc_t rd_data;
    logic season_frozen;
    logic month_frozen;
  } tua_state_t;

  tua_state_t s;
  tua_state_t next_s;

  tua_mem_if #(.W(SCHED_W), .AW(CAL_AW)) cal_bus ();
  tua_mem_if #(.W(RATE_W), .AW(SCH_AW)) sch_bus ();

  tua_mem #(.W(SCHED_W), .AW(CAL_AW), .DEPTH(CAL_DEPTH)) u_cal_mem (
    .clk(clk),
    .reset(reset),
    .m(cal_bus.mem)
  );

  tua_mem #(.W(RATE_W), .AW(SCH_AW), .DEPTH(SCH_DEPTH)) u_sch_mem (
    .clk(clk),
    .reset(reset),
    .m(sch_bus.mem)
  );

  // Two tag comparators per stored calendar, one for this year and one for the next
  logic [NUM_CAL-1:0] match_cur;
  logic [NUM_CAL-1:0] match_nxt;
  logic [NUM_CAL-1:0] tag_sel;
  logic [YEAR_W-1:0] next_year;

  assign next_year = YEAR_W'(rtc_year + 1'b1);

  for (genvar gi = 0; gi < NUM_CAL; gi++)
  begin : g_tag
    assign match_cur[gi] = s.tag_valid[gi] && (s.tag_year[gi] == rtc_year);
    assign match_nxt[gi] = s.tag_valid[gi] && (s.tag_year[gi] == next_year);
    // Slot numbers past the last calendar decode to no entry, so they are ignored
    assign tag_sel[gi] = cal_tag_wr && (cal_tag_slot == CAL_IDX_W'(gi));
  end

  // Returns {found, slot} of the lowest matching calendar slot
  function automatic logic [CAL_IDX_W:0] find_cal(
    input logic [NUM_CAL-1:0] match
  );
    logic [CAL_IDX_W:0] r;
    r = '0;
    for (int i = NUM_CAL - 1; i >= 0; i--)
    begin
      if (match[i])
      begin
        r = {1'b1, CAL_IDX_W'(i)};
      end
    end
    return r;
  endfunction : find_cal

  // Next season start strictly after today, else the earliest (next year)
  function automatic tua_date_t next_season(
    input tua_date_t today,
    input logic [NUM_SEASON-1:0][DATE_W-1:0] starts
  );
    tua_date_t best;
    tua_date_t low;
    logic hit;
    best = '1;
    low = '1;
    hit = 1'b0;
    for (int i = 0; i < NUM_SEASON; i++)
    begin
      if (starts[i] < low)
      begin
        low = starts[i];
      end
      if ((starts[i] > today) && (starts[i] <= best))
      begin
        best = starts[i];
        hit = 1'b1;
      end
    end
    return hit ? best : low;
  endfunction : next_season

  // Billing date of this month if still ahead, else that of the next month
  function automatic tua_date_t next_bill(
    input tua_date_t today,
    input logic [NUM_MONTH-1:0][4:0] bills
  );
    logic [3:0] mon;
    logic [3:0] nmon;
    logic [4:0] bday;
    mon = today[DATE_W-1:5];
    if ((mon < FIRST_MONTH) || (mon > LAST_MONTH))
    begin
      mon = FIRST_MONTH;
    end
    nmon = (mon == LAST_MONTH) ? FIRST_MONTH : 4'(mon + FIRST_MONTH);
    bday = bills[4'(mon - FIRST_MONTH)];
    if (today[4:0] < bday)
    begin
      return {mon, bday};
    end
    return {nmon, bills[4'(nmon - FIRST_MONTH)]};
  endfunction : next_bill

  tua_date_t today;
  logic day_start;
  logic year_end;
  logic [CAL_IDX_W:0] cur_cal;
  logic [CAL_IDX_W:0] nxt_cal;
  logic [SLOT_W-1:0] slot_idx;
  logic [RATE_W-1:0] rate;
  logic season_close;
  logic month_close;
  logic last_close;

  assign today = {rtc_month, rtc_day};
  assign day_start = rtc_tick && (rtc_hour == '0) && (rtc_minute == '0) && (rtc_second == '0);
  assign year_end = rtc_tick && (rtc_month == LAST_MONTH) && (rtc_day == LAST_DAY)
                    && (rtc_hour == LAST_HOUR) && (rtc_minute == LAST_MIN) && (rtc_second == LAST_SEC);
  assign cur_cal = find_cal(match_cur);
  assign nxt_cal = find_cal(match_nxt);
  assign slot_idx = SLOT_W'(rtc_hour * SLOTS_PER_HOUR + rtc_minute / MIN_PER_SLOT);

  // Host loads run on the write port only, the lookup keeps going
  assign cal_bus.we = cal_wr_en;
  assign cal_bus.waddr = CAL_AW'(cal_wr_slot * DAYS_PER_CAL + cal_wr_day);
  assign cal_bus.wdata = cal_wr_sched;
  assign cal_bus.raddr_a = CAL_AW'(s.cal_slot * DAYS_PER_CAL + rtc_doy);
  assign cal_bus.raddr_b = CAL_AW'(cal_rd_slot * DAYS_PER_CAL + cal_rd_day);
  assign sch_bus.we = sch_wr_en;
  assign sch_bus.waddr = SCH_AW'(sch_wr_id * SLOTS_PER_DAY + sch_wr_slot);
  assign sch_bus.wdata = sch_wr_rate;
  // Two-stage lookup; the rate lags the day by two clocks and the slot by one
  assign sch_bus.raddr_a = SCH_AW'(cal_bus.rdata_a * SLOTS_PER_DAY + slot_idx);
  assign sch_bus.raddr_b = SCH_AW'(sch_rd_id * SLOTS_PER_DAY + sch_rd_slot);
  assign rate = sch_bus.rdata_a;

  // One decode per rate; for two clocks after a calendar switch the rate from the old calendar is still used
  logic [NUM_RATE-1:0] rate_hit;
  for (genvar gr = 0; gr < NUM_RATE; gr++)
  begin : g_rate
    assign rate_hit[gr] = energy_valid && !s.halted && (rate == RATE_W'(gr));
  end

  // A wrapped end date meets day_start only after the new year begins
  assign season_close = !s.halted && day_start && (today == s.season_end);
  assign month_close = !s.halted && day_start && (today == s.month_end);
  assign last_close = !s.halted && year_end && !nxt_cal[CAL_IDX_W];

  always_comb
  begin
    next_s = s;
    next_s.season_frozen = 1'b0;
    next_s.month_frozen = 1'b0;

    for (int i = 0; i < NUM_CAL; i++)
    begin
      if (tag_sel[i])
      begin
        next_s.tag_valid[i] = cal_tag_valid;
        next_s.tag_year[i] = cal_tag_year;
      end
    end

    if (season_close || last_close)
    begin
      next_s.season_frz = s.season_act;
      next_s.season_act = '0;
      next_s.season_end = next_season(today, cfg_season_start);
      next_s.season_frozen = 1'b1;
    end

    if (month_close || last_close)
    begin
      next_s.month_frz = s.month_act;
      next_s.month_act = '0;
      next_s.month_end = next_bill(today, cfg_bill_day);
      next_s.month_frozen = 1'b1;
    end

    // A calendar replaced mid-period takes over only once a period ends
    if ((season_close || month_close) && cur_cal[CAL_IDX_W])
    begin
      next_s.cal_slot = cur_cal[CAL_IDX_W-1:0];
    end

    if (!s.halted && year_end)
    begin
      if (nxt_cal[CAL_IDX_W])
      begin
        next_s.cal_slot = nxt_cal[CAL_IDX_W-1:0];
      end
      else
      begin
        next_s.halted = 1'b1;
      end
    end

    // Start after reset or after a halt once a calendar for this year exists
    if (s.halted && cur_cal[CAL_IDX_W])
    begin
      next_s.halted = 1'b0;
      next_s.cal_slot = cur_cal[CAL_IDX_W-1:0];
      next_s.season_end = next_season(today, cfg_season_start);
      next_s.month_end = next_bill(today, cfg_bill_day);
    end

    // Reset touches active sets only; frozen sets stay as they are
    if (acc_reset)
    begin
      next_s.season_act = '0;
      next_s.month_act = '0;
      next_s.season_end = next_season(today, cfg_season_start);
      next_s.month_end = next_bill(today, cfg_bill_day);
      if (cur_cal[CAL_IDX_W])
      begin
        next_s.cal_slot = cur_cal[CAL_IDX_W-1:0];
      end
    end

    // Added after any clear so the increment lands in the new period
    for (int i = 0; i < NUM_RATE; i++)
    begin
      if (rate_hit[i])
      begin
        next_s.season_act[i] = ACC_W'(next_s.season_act[i] + energy_inc);
        next_s.month_act[i] = ACC_W'(next_s.month_act[i] + energy_inc);
      end
    end

    case (rd_set)
      SET_SEASON_ACTIVE: next_s.rd_data = s.season_act[rd_rate];
      SET_SEASON_FROZEN: next_s.rd_data = s.season_frz[rd_rate];
      SET_MONTH_ACTIVE: next_s.rd_data = s.month_act[rd_rate];
      SET_MONTH_FROZEN: next_s.rd_data = s.month_frz[rd_rate];
      default: next_s.rd_data = '0;
    endcase
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      s <= '0;
      s.halted <= 1'b1;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign cal_rd_sched = cal_bus.rdata_b;
  assign sch_rd_rate = sch_bus.rdata_b;
  assign rd_data = s.rd_data;
  assign running = !s.halted;
  assign active_cal = s.cal_slot;
  assign season_frozen = s.season_frozen;
  assign month_frozen = s.month_frozen;
endmodule : tua_accum

// file: test/tua_accum_sva.sv
// Purpose: Port checker of the time-of-use accumulator
// Assumes: One clock domain, asynchronous reset
// Notes: Freeze pulses may trail their tick by one or two edges
`timescale 1ns/1ps
module tua_accum_sva (
  input wire logic clk,
  input wire logic reset,
  input wire logic rtc_tick,
  input wire logic [3:0] rtc_month,
  input wire logic [4:0] rtc_day,
  input wire logic [4:0] rtc_hour,
  input wire logic [5:0] rtc_minute,
  input wire logic [5:0] rtc_second,
  input wire logic sch_wr_en,
  input wire logic [tua_pkg::SCHED_W-1:0] sch_rd_id,
  input wire logic [tua_pkg::SLOT_W-1:0] sch_rd_slot,
  input wire logic [tua_pkg::RATE_W-1:0] sch_rd_rate,
  input wire tua_pkg::tua_set_t rd_set,
  input wire logic [tua_pkg::RATE_W-1:0] rd_rate,
  input wire tua_pkg::tua_acc_t rd_data,
  input wire logic running,
  input wire logic season_frozen,
  input wire logic month_frozen
);
  import tua_pkg::*;
  logic [1:0] ye_d;
  logic [1:0] tk_d;
  wire logic ye = rtc_tick && rtc_month == LAST_MONTH && rtc_day == LAST_DAY && rtc_hour == LAST_HOUR
    && rtc_minute == LAST_MIN && rtc_second == LAST_SEC;
  wire logic mid = rtc_tick && rtc_hour == 5'h00 && rtc_minute == 6'h00 && rtc_second == 6'h00;
  wire logic frz = season_frozen || month_frozen;
  // Two-deep history so either freeze latency is accepted
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ye_d <= 2'h0;
      tk_d <= 2'h0;
    end
    else
    begin
      ye_d <= {ye_d[0], ye};
      tk_d <= {tk_d[0], ye || mid};
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  reset_idle_a: assert property ($fell(reset) |-> !running && !frz && rd_data == '0)
    else $error("outputs not idle after reset");
  month_pulse_a: assert property (month_frozen |=> !month_frozen)
    else $error("month freeze pulse too long");
  season_pulse_a: assert property (season_frozen |=> !season_frozen)
    else $error("season freeze pulse too long");
  month_tick_a: assert property (month_frozen |-> |tk_d)
    else $error("month freeze without midnight tick");
  season_tick_a: assert property (season_frozen |-> |tk_d)
    else $error("season freeze without midnight tick");
  halt_yearend_a: assert property ($fell(running) |-> |ye_d)
    else $error("running dropped outside year end");
  frozen_hold_a: assert property ((rd_set == SET_MONTH_FROZEN || rd_set == SET_SEASON_FROZEN)
    && $stable(rd_set) && $stable(rd_rate) |=> $stable(rd_data) || frz || $past(frz))
    else $error("frozen value changed without freeze");
  sched_read_a: assert property (!$past(reset) && $stable(sch_rd_id) && $stable(sch_rd_slot) && !sch_wr_en
    && !$past(sch_wr_en) |=> $stable(sch_rd_rate))
    else $error("schedule readback changed without write");
  month_c: cover property (month_frozen);
  season_c: cover property (season_frozen);
  halt_c: cover property ($fell(running));
endmodule : tua_accum_sva
bind tua_accum tua_accum_sva u_tua_accum_sva (.clk(clk), .reset(reset), .rtc_tick(rtc_tick),
  .rtc_month(rtc_month), .rtc_day(rtc_day), .rtc_hour(rtc_hour), .rtc_minute(rtc_minute),
  .rtc_second(rtc_second), .sch_wr_en(sch_wr_en), .sch_rd_id(sch_rd_id), .sch_rd_slot(sch_rd_slot),
  .sch_rd_rate(sch_rd_rate), .rd_set(rd_set), .rd_rate(rd_rate), .rd_data(rd_data), .running(running),
  .season_frozen(season_frozen), .month_frozen(month_frozen));

// file: test/tua_meter_model.sv
// Purpose: Metering engine and time base seen by the accumulator
// Assumes: Requests come from the bench on the falling edge
// Notes: Energy data is scrambled while no increment is offered
`timescale 1ns/1ps
module tua_meter_model (
  input wire logic clk,
  input wire logic tick_req,
  input wire logic inc_req,
  input wire logic [tua_pkg::INC_W-1:0] inc_val,
  output logic rtc_tick,
  output logic energy_valid,
  output logic [tua_pkg::INC_W-1:0] energy_inc
);
  import tua_pkg::*;
  initial
  begin
    rtc_tick = 1'h0;
    energy_valid = 1'h0;
    energy_inc = '0;
  end
  // Toggling idle data catches a design that ignores energy_valid
  always @(negedge clk)
  begin
    rtc_tick <= tick_req;
    energy_valid <= inc_req;
    energy_inc <= inc_req ? inc_val : ~energy_inc;
  end
endmodule : tua_meter_model

// file: test/test_tua_accum.sv
// Purpose: Self-checking bench of the time-of-use accumulator
// Assumes: Calendar slot 0 uses schedule 3, rate 5
// Notes: Readbacks are queued; a monitor compares them as they appear
`timescale 1ns/1ps
module test_tua_accum;
  import tua_pkg::*;
  logic clk = 1'h0;
  logic reset = 1'h1;
  logic tick_req = 1'h0;
  logic inc_req = 1'h0;
  logic rd_req = 1'h0;
  logic rd_q = 1'h0;
  logic wr_en = 1'h0;
  logic tag_wr = 1'h0;
  logic acc_reset = 1'h0;
  logic [INC_W-1:0] inc_val = '0;
  logic [34:0] tm = {4'h1, 5'h0B, 5'h01, 6'h1E, 6'h00, 9'h00A};
  logic [CAL_IDX_W-1:0] cs = '0;
  logic [DOY_W-1:0] cday = '0;
  logic [SLOT_W-1:0] sslot = '0;
  logic [SCHED_W-1:0] sid = 4'h3;
  logic [RATE_W-1:0] rt = 3'h5;
  tua_set_t rd_set = SET_SEASON_ACTIVE;
  logic rtc_tick, energy_valid, running, season_frozen, month_frozen;
  logic [INC_W-1:0] energy_inc;
  logic [SCHED_W-1:0] cal_rd_sched;
  logic [RATE_W-1:0] sch_rd_rate;
  tua_acc_t rd_data, s1, sum;
  logic [31:0] seed = 32'h2D;
  logic [YEAR_W-1:0] yr = 8'h18;
  logic [YEAR_W-1:0] tyr = 8'h18;
  logic [CAL_IDX_W-1:0] active_cal;
  logic [CAL_IDX_W-1:0] acal = 5'h00;
  logic [44:0] exp_q[$];
  int mismatches = 0;
  int n_compared = 0;
  always #12.5 clk = ~clk;
  tua_meter_model u_tua_meter_model (.clk(clk), .tick_req(tick_req), .inc_req(inc_req), .inc_val(inc_val),
    .rtc_tick(rtc_tick), .energy_valid(energy_valid), .energy_inc(energy_inc));
  tua_accum u_tua_accum (.clk(clk), .reset(reset), .rtc_tick(rtc_tick), .rtc_year(yr),
    .rtc_month(tm[34:31]), .rtc_day(tm[30:26]), .rtc_hour(tm[25:21]), .rtc_minute(tm[20:15]),
    .rtc_second(tm[14:9]), .rtc_doy(tm[8:0]), .energy_valid(energy_valid), .energy_inc(energy_inc),
    .cal_wr_en(wr_en), .cal_wr_slot(cs), .cal_wr_day(cday), .cal_wr_sched(sid), .cal_tag_wr(tag_wr),
    .cal_tag_slot(cs), .cal_tag_year(tyr), .cal_tag_valid(1'h1), .sch_wr_en(wr_en), .sch_wr_id(sid),
    .sch_wr_slot(sslot), .sch_wr_rate(rt), .cfg_season_start({9'h021, 9'h141, 9'h0E1, 9'h081}),
    .cfg_bill_day({12{5'h14}}), .acc_reset(acc_reset), .cal_rd_slot(cs), .cal_rd_day(cday),
    .cal_rd_sched(cal_rd_sched), .sch_rd_id(sid), .sch_rd_slot(sslot), .sch_rd_rate(sch_rd_rate),
    .rd_set(rd_set), .rd_rate(rt), .rd_data(rd_data), .running(running), .active_cal(active_cal),
    .season_frozen(season_frozen), .month_frozen(month_frozen));
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    xs = y ^ (y << 5);
  endfunction : xs
  function automatic logic [44:0] ex(input logic r, input tua_acc_t d);
    ex = {acal, r, 3'h5, 4'h3, d};
  endfunction : ex
  task automatic check(input logic [44:0] seen, input logic [44:0] want);
    n_compared++;
    if (seen !== want)
    begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
    end
  endtask : check
  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude
  task automatic wr(input logic [8:0] d, input logic [6:0] s);
    @(negedge clk);
    cday <= d;
    sslot <= s;
    wr_en <= 1'h1;
    @(negedge clk);
    wr_en <= 1'h0;
  endtask : wr
  task automatic tag(input logic [4:0] s, input logic [7:0] y);
    @(negedge clk);
    cs <= s;
    tyr <= y;
    tag_wr <= 1'h1;
    @(negedge clk);
    tag_wr <= 1'h0;
    cs <= 5'h00;
    repeat (2) @(negedge clk);
  endtask : tag
  task automatic rd(input tua_set_t s, input logic [2:0] r, input logic [44:0] e);
    @(negedge clk);
    rd_set <= s;
    rt <= r;
    rd_req <= 1'h1;
    exp_q.push_back(e);
    @(negedge clk);
    rd_req <= 1'h0;
    repeat (2) @(negedge clk);
  endtask : rd
  task automatic pump(input int n);
    repeat (n)
    begin
      @(negedge clk);
      seed = xs(seed);
      inc_val <= seed[15:0];
      inc_req <= 1'h1;
      sum = sum + {16'h0000, seed[15:0]};
    end
    @(negedge clk);
    inc_req <= 1'h0;
    repeat (4) @(negedge clk);
  endtask : pump
  // The year advances once the year-end tick has passed, as the time base would do
  task automatic tick_with(input logic [15:0] v, input logic roll);
    @(negedge clk);
    tick_req <= 1'h1;
    inc_req <= (v != 16'h0000);
    inc_val <= v;
    @(negedge clk);
    tick_req <= 1'h0;
    inc_req <= 1'h0;
    @(negedge clk);
    if (roll)
      yr <= yr + 8'h01;
    repeat (3) @(negedge clk);
  endtask : tick_with
  always @(posedge clk)
  begin
    rd_q <= rd_req;
    if (rd_q)
      check({active_cal, running, sch_rd_rate, cal_rd_sched, rd_data}, exp_q.pop_front());
  end
  initial
  begin
    repeat (2) @(negedge clk);
    reset <= 1'h0;
    wr(9'h00A, 7'h06);
    wr(9'h00A, 7'h00);
    wr(9'h16D, 7'h5F);
    tag(5'h14, 8'h18);
    rd(SET_SEASON_ACTIVE, 3'h5, ex(1'h0, '0));
    tag(5'h00, 8'h18);
    rd(SET_SEASON_ACTIVE, 3'h5, ex(1'h1, '0));
    $display("test load done");
    sum = '0;
    pump(8);
    s1 = sum;
    rd(SET_SEASON_ACTIVE, 3'h5, ex(1'h1, s1));
    rd(SET_MONTH_ACTIVE, 3'h5, ex(1'h1, s1));
    rd(SET_SEASON_ACTIVE, 3'h2, ex(1'h1, '0));
    $display("test accumulate done");
    tm <= {4'h1, 5'h14, 5'h00, 6'h00, 6'h00, 9'h00A};
    repeat (4) @(negedge clk);
    tick_with(16'h00A5, 1'h0);
    rd(SET_MONTH_FROZEN, 3'h5, ex(1'h1, s1));
    rd(SET_MONTH_ACTIVE, 3'h5, ex(1'h1, 32'h000000A5));
    rd(SET_SEASON_ACTIVE, 3'h5, ex(1'h1, s1 + 32'h000000A5));
    rd(SET_SEASON_FROZEN, 3'h5, ex(1'h1, '0));
    $display("test month close done");
    tag(5'h00, 8'h18);
    @(negedge clk);
    acc_reset <= 1'h1;
    @(negedge clk);
    acc_reset <= 1'h0;
    rd(SET_SEASON_ACTIVE, 3'h5, ex(1'h1, '0));
    rd(SET_MONTH_FROZEN, 3'h5, ex(1'h1, s1));
    $display("test reset done");
    tm <= {4'hC, 5'h1F, 5'h17, 6'h3B, 6'h3B, 9'h16D};
    tag(5'h01, 8'h19);
    sum = '0;
    pump(2);
    tick_with(16'h0000, 1'h1);
    acal = 5'h01;
    rd(SET_SEASON_ACTIVE, 3'h5, ex(1'h1, sum));
    rd(SET_SEASON_FROZEN, 3'h5, ex(1'h1, '0));
    $display("test year roll done");
    tick_with(16'h0000, 1'h1);
    rd(SET_SEASON_FROZEN, 3'h5, ex(1'h0, sum));
    rd(SET_MONTH_FROZEN, 3'h5, ex(1'h0, sum));
    pump(1);
    rd(SET_SEASON_ACTIVE, 3'h5, ex(1'h0, '0));
    $display("test year end done");
    conclude();
  end
  initial
  begin
    #25000;
    mismatches++;
    conclude();
  end
endmodule : test_tua_accum
